// ==== core/ipfm_map.svh ====
`ifndef IPFM_MAP_SVH
`define IPFM_MAP_SVH

// Clock rate in hertz.
`define IPFM_CLK_HZ        20000000
// Shortest measurable period in microseconds.
`define IPFM_MIN_PERIOD_US 200
// Longest measurable period in microseconds.
`define IPFM_MAX_PERIOD_US 33300
// Shortest period in clock cycles, rounded down.
`define IPFM_MIN_CYC  ((`IPFM_CLK_HZ / 1000000) * `IPFM_MIN_PERIOD_US)
// Longest period in clock cycles, rounded down.
`define IPFM_MAX_CYC  ((`IPFM_CLK_HZ / 1000000) * `IPFM_MAX_PERIOD_US)
// Clock cycles in one millisecond.
`define IPFM_CYC_PER_MS    (`IPFM_CLK_HZ / 1000)
// Channel selector codes.
`define IPFM_CH_ONE        8'h00
`define IPFM_CH_TWO        8'h01
// Error byte values.
`define IPFM_ERR_NONE      8'h00
`define IPFM_ERR_CHANNEL   8'h01
`define IPFM_ERR_HIGH      8'h02
`define IPFM_ERR_LOW       8'h04

`endif

// ==== core/ipfm_pkg.sv ====
`default_nettype none

package ipfm_pkg;

    // Measurement results handed to the controller.
    typedef struct packed {
        logic [15:0] period_ms;
        logic [15:0] freq_hz;
        logic [7:0]  fault;
    } ipfm_result_s;

    // Divider sequencer states.
    typedef enum logic [2:0] {
        IPFM_IDLE = 3'b001,
        IPFM_DIV  = 3'b010,
        IPFM_DONE = 3'b100
    } ipfm_div_e;

endpackage

`default_nettype wire

// ==== core/ipfm_divider.sv ====
`timescale 1ns/1ps
`default_nettype none

module ipfm_divider (
    input  wire logic        sys_clk,
    input  wire logic        rst_sync_n,
    input  wire logic        start,
    input  wire logic [31:0] dividend,
    input  wire logic [31:0] divisor,
    output logic             done,
    output logic [31:0]      quotient
);

    logic [31:0] rem;
    logic [31:0] quo;
    logic [5:0]  count;
    logic        busy;
    logic [32:0] trial;

    // Trial subtraction of the shifted remainder.
    always_comb begin
        trial = {rem, quo[31]} - {1'b0, divisor};
    end

    // Restoring divider, one quotient bit per clock, 32 cycles per result.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rem      <= 32'h0000_0000;
            quo      <= 32'h0000_0000;
            count    <= 6'h00;
            busy     <= 1'b0;
            done     <= 1'b0;
            quotient <= 32'h0000_0000;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                rem   <= 32'h0000_0000;
                quo   <= dividend;
                count <= 6'h20;
                busy  <= 1'b1;
            end else if (busy) begin
                if (!trial[32]) begin
                    rem <= trial[31:0];
                    quo <= {quo[30:0], 1'b1};
                end else begin
                    rem <= {rem[30:0], quo[31]};
                    quo <= {quo[30:0], 1'b0};
                end
                count <= count - 6'h01;
                if (count == 6'h01) begin
                    busy     <= 1'b0;
                    done     <= 1'b1;
                    quotient <= trial[32] ? {quo[30:0], 1'b0} : {quo[30:0], 1'b1};
                end
            end
        end
    end

endmodule

`default_nettype wire

// ==== core/ipfm_meter.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ipfm_map.svh"

module ipfm_meter (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        measure_on,
    input  wire logic [7:0]  channel_sel,
    input  wire logic        freq_input_one,
    input  wire logic        freq_input_two,
    output logic [15:0]      period_ms,
    output logic [15:0]      freq_hz,
    output logic [7:0]       error_out,
    output logic             result_valid
);

    //////////////////////////////////////////////////////////////////////////
    // Reset release.

    logic        rst_meta_n;
    logic        rst_sync_n;

    // Two-stage release of the asynchronous reset.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Channel selection and edge detection.

    // Returns true when the selector names a real frequency channel.
    function automatic logic channel_ok(input logic [7:0] sel);
        channel_ok = (sel == `IPFM_CH_ONE) || (sel == `IPFM_CH_TWO);
    endfunction

    logic        sel_level;
    logic        sel_prev;
    logic        rise;
    logic [7:0]  sel_prev_code;
    logic        active;

    // Pick the chosen input; an invalid code reads as low.
    always_comb begin
        if (channel_sel == `IPFM_CH_ONE) begin
            sel_level = freq_input_one;
        end else if (channel_sel == `IPFM_CH_TWO) begin
            sel_level = freq_input_two;
        end else begin
            sel_level = 1'b0;
        end
        active = measure_on && channel_ok(channel_sel);
        rise   = active && sel_level && !sel_prev && (sel_prev_code == channel_sel);
    end

    // Previous input level and selector, so a channel switch is not taken as an edge.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sel_prev      <= 1'b0;
            sel_prev_code <= 8'h00;
        end else begin
            sel_prev      <= sel_level;
            sel_prev_code <= channel_sel;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Period counter.

    logic [31:0] cycles;
    logic        armed;
    logic        timeout;
    logic        too_fast;
    logic        too_slow;
    logic        capture;
    logic [31:0] captured;

    // Counter would pass the longest period with no closing edge.
    assign timeout = armed && (cycles >= 32'(`IPFM_MAX_CYC));

    // Count cycles between rising edges; a timeout disarms until the next edge.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cycles   <= 32'h0000_0000;
            armed    <= 1'b0;
            capture  <= 1'b0;
            captured <= 32'h0000_0000;
        end else begin
            capture <= 1'b0;
            if (!active) begin
                armed  <= 1'b0;
                cycles <= 32'h0000_0000;
            end else if (rise) begin
                if (armed && !timeout) begin
                    capture  <= 1'b1;
                    captured <= cycles + 32'h0000_0001;
                end
                armed  <= 1'b1;
                cycles <= 32'h0000_0000;
            end else if (timeout) begin
                armed  <= 1'b0;
                cycles <= 32'h0000_0000;
            end else if (armed) begin
                cycles <= cycles + 32'h0000_0001;
            end
        end
    end

    // Range flags for the captured period.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            too_fast <= 1'b0;
            too_slow <= 1'b0;
        end else if (!active) begin
            too_fast <= 1'b0;
            too_slow <= 1'b0;
        end else if (timeout) begin
            too_slow <= 1'b1;
        end else if (capture) begin
            too_fast <= captured < 32'(`IPFM_MIN_CYC);
            too_slow <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Frequency and period conversion.

    ipfm_pkg::ipfm_div_e state;
    logic        div_start;
    logic        div_done;
    logic [31:0] div_num;
    logic [31:0] div_den;
    logic [31:0] div_q;
    logic        conv_period;

    ipfm_divider u_div (
        .sys_clk    (sys_clk),
        .rst_sync_n (rst_sync_n),
        .start      (div_start),
        .dividend   (div_num),
        .divisor    (div_den),
        .done       (div_done),
        .quotient   (div_q)
    );

    // Predicts the high-rate flag for the capture in flight.
    function automatic logic too_fast_next();
        too_fast_next = captured < 32'(`IPFM_MIN_CYC);
    endfunction

    // Two divisions per period: clock rate over cycles, then cycles over cycles per ms.
    // The second division is launched from the gap state, or the sequencer would wait forever.
    always_comb begin
        div_start = ((state == ipfm_pkg::IPFM_IDLE) && capture && !too_fast_next())
                  || (state == ipfm_pkg::IPFM_DONE);
        div_num   = conv_period ? captured : 32'(`IPFM_CLK_HZ);
        div_den   = conv_period ? 32'(`IPFM_CYC_PER_MS) : captured;
    end

    ipfm_pkg::ipfm_result_s res;
    logic        res_new;

    // Sequencer for the two divisions and the result update.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state       <= ipfm_pkg::IPFM_IDLE;
            conv_period <= 1'b0;
            res         <= '0;
            res_new     <= 1'b0;
        end else begin
            // Marks that both halves of a result now stand in res.
            res_new <= (state == ipfm_pkg::IPFM_DIV) && div_done && conv_period;
            unique case (state)
                ipfm_pkg::IPFM_IDLE: begin
                    conv_period <= 1'b0;
                    if (div_start) begin
                        state <= ipfm_pkg::IPFM_DIV;
                    end
                end
                ipfm_pkg::IPFM_DIV: begin
                    if (div_done && !conv_period) begin
                        res.freq_hz <= div_q[15:0];
                        conv_period <= 1'b1;
                        state       <= ipfm_pkg::IPFM_DONE;
                    end else if (div_done) begin
                        res.period_ms <= div_q[15:0];
                        state         <= ipfm_pkg::IPFM_IDLE;
                    end
                end
                ipfm_pkg::IPFM_DONE: begin
                    state <= ipfm_pkg::IPFM_DIV;
                end
                default: begin
                    state <= ipfm_pkg::IPFM_IDLE;
                end
            endcase
            res.fault <= (channel_ok(channel_sel) ? `IPFM_ERR_NONE : `IPFM_ERR_CHANNEL)
                       | (too_fast ? `IPFM_ERR_HIGH : `IPFM_ERR_NONE)
                       | (too_slow ? `IPFM_ERR_LOW : `IPFM_ERR_NONE);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Registered outputs.

    // Present results from flops; period, frequency and valid all move on one edge.
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            period_ms    <= 16'h0000;
            freq_hz      <= 16'h0000;
            error_out    <= 8'h00;
            result_valid <= 1'b0;
        end else begin
            if (res_new) begin
                period_ms <= res.period_ms;
                freq_hz   <= res.freq_hz;
            end
            error_out    <= res.fault;
            result_valid <= res_new;
        end
    end

endmodule

`default_nettype wire

// ==== dv/ipfm_meter_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none

module ipfm_meter_asserts (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        measure_on,
    input wire logic [7:0]  channel_sel,
    input wire logic        freq_input_one,
    input wire logic        freq_input_two,
    input wire logic [15:0] period_ms,
    input wire logic [15:0] freq_hz,
    input wire logic [7:0]  error_out,
    input wire logic        result_valid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic [7:0] off_cnt;

    // Counts disabled cycles, so a conversion still in flight is given time to land.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            off_cnt <= 8'h00;
        end else if (measure_on) begin
            off_cnt <= 8'h00;
        end else if (off_cnt != 8'h64) begin
            off_cnt <= off_cnt + 8'h01;
        end
    end

    // Selector steady long enough to cover the two-cycle lag of the error byte.
    sequence bad_sel;
        (measure_on && channel_sel > 8'h01) [*3];
    endsequence
    sequence good_sel;
        (measure_on && channel_sel <= 8'h01) [*3];
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    chk_valid_pulse: assert property (result_valid |=> !result_valid)
        else $error("result pulse longer than one cycle");
    chk_hold_out: assert property (!result_valid |-> $stable(period_ms) && $stable(freq_hz))
        else $error("results moved without a result pulse");
    chk_off_quiet: assert property (off_cnt == 8'h64 |-> !result_valid)
        else $error("result while disabled");
    chk_off_clear: assert property (!measure_on [*4] |-> error_out[2:1] == 2'b00)
        else $error("range faults not clear while disabled");
    chk_bad_chan: assert property (bad_sel |-> error_out[0])
        else $error("bad channel not flagged");
    chk_good_chan: assert property (good_sel |-> !error_out[0])
        else $error("valid channel flagged");
    chk_result_range: assert property (result_valid |-> freq_hz >= 16'h001e
        && freq_hz <= 16'h1388 && period_ms <= 16'h0021)
        else $error("result outside measurable span");
    // Both values truncate, so exactly 1000 Hz may pair with either 0 ms or 1 ms.
    chk_unit_pair: assert property (result_valid |->
        (freq_hz <= 16'h03e8 || period_ms == 16'h0000)
        && (freq_hz >= 16'h03e8 || period_ms != 16'h0000))
        else $error("period and frequency disagree");
    chk_spare_bits: assert property (error_out[7:3] == 5'h00)
        else $error("undefined error bit set");
    chk_low_hold: assert property ($rose(error_out[2]) |->
        $stable(period_ms) && $stable(freq_hz) && !result_valid)
        else $error("results changed on too-low fault");
endmodule

bind ipfm_meter ipfm_meter_asserts u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .measure_on(measure_on),
    .channel_sel(channel_sel), .freq_input_one(freq_input_one),
    .freq_input_two(freq_input_two), .period_ms(period_ms), .freq_hz(freq_hz),
    .error_out(error_out), .result_valid(result_valid));

`default_nettype wire

// ==== dv/ipfm_pulse_src.sv ====
`timescale 1ns/1ps
`default_nettype none

module ipfm_pulse_src (
    input  wire logic        sys_clk,
    input  wire logic        run,
    input  wire logic        to_two,
    input  wire logic [31:0] period,
    output logic             freq_input_one,
    output logic             freq_input_two
);
    logic [31:0] cnt;

    // Rising edges come period clocks apart; a fixed short high time avoids stray edges on a change.
    always_ff @(posedge sys_clk) begin
        if (!run || cnt >= period - 32'h1) begin
            cnt <= 32'h0;
        end else begin
            cnt <= cnt + 32'h1;
        end
    end

    // The unused line rests low, as a pulled-down sensor input would.
    assign freq_input_one = run && !to_two && cnt < 32'h64;
    assign freq_input_two = run && to_two && cnt < 32'h64;
endmodule

`default_nettype wire

// ==== dv/ipfm_meter_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ipfm_map.svh"

module ipfm_meter_tb;
    logic        sys_clk = 1'b0;
    logic        rst_n, measure_on, in_one, in_two, result_valid, src_run, src_two;
    logic [7:0]  channel_sel, error_out;
    logic [15:0] period_ms, freq_hz;
    logic [31:0] src_period;
    int          n_mismatch = 0, n_checks = 0, n_valid = 0, n_cycles = 0, start;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, results counter and hang guard.
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        n_cycles++;
        if (result_valid === 1'b1) n_valid++;
        if (n_cycles == 90000) begin
            n_mismatch++;
            end_sim();
        end
    end

    ipfm_meter dut (.sys_clk(sys_clk), .rst_n(rst_n), .measure_on(measure_on),
        .channel_sel(channel_sel), .freq_input_one(in_one), .freq_input_two(in_two),
        .period_ms(period_ms), .freq_hz(freq_hz), .error_out(error_out),
        .result_valid(result_valid));
    ipfm_pulse_src u_src (.sys_clk(sys_clk), .run(src_run), .to_two(src_two),
        .period(src_period), .freq_input_one(in_one), .freq_input_two(in_two));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Waits a fixed span of source clocks and confirms no result was produced.
    task automatic idle(input int cyc);
        start = n_valid;
        repeat (cyc) @(posedge sys_clk);
        #1;
        check("results", 16'(n_valid - start), 16'h0000);
    endtask

    // The second result after a change is compared, so a mixed first interval is harmless.
    task automatic measure(input logic [7:0] sel, input int cyc);
        channel_sel = sel;
        src_two = sel[0];
        src_period = 32'(cyc);
        start = n_valid;
        for (int i = 0; i < 4 * cyc + 500 && n_valid < start + 2; i++) @(posedge sys_clk);
        #1;
        check("period_ms", period_ms, 16'(cyc / `IPFM_CYC_PER_MS));
        check("freq_hz", freq_hz, 16'(`IPFM_CLK_HZ / cyc));
        check("error_out", 16'(error_out), 16'(`IPFM_ERR_NONE));
        $display("measure %0d cycles done", cyc);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: ranges, too-high, bad channels, then disable.
    initial begin
        rst_n = 1'b0;
        measure_on = 1'b0;
        channel_sel = `IPFM_CH_ONE;
        src_run = 1'b0;
        src_two = 1'b0;
        src_period = 32'h0fa0;
        repeat (16) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 measure_on = 1'b1;
        src_run = 1'b1;
        measure(`IPFM_CH_ONE, 4000);
        measure(`IPFM_CH_TWO, 20000);
        measure(`IPFM_CH_ONE, 6000);
        src_period = 32'h0f9f;
        idle(6000);
        check("error_out", 16'(error_out), 16'(`IPFM_ERR_HIGH));
        check("freq_hz", freq_hz, 16'h0d05);
        $display("too high done");
        channel_sel = 8'h02;
        src_period = 32'h0fa0;
        repeat (4) @(posedge sys_clk);
        #1 check("error_out", 16'(error_out), 16'(`IPFM_ERR_CHANNEL));
        channel_sel = 8'hff;
        idle(1000);
        check("error_out", 16'(error_out[0]), 16'h0001);
        $display("bad channel done");
        channel_sel = `IPFM_CH_ONE;
        measure_on = 1'b0;
        idle(1000);
        check("error_out", 16'(error_out), 16'h0000);
        $display("disable done");
        end_sim();
    end
endmodule

`default_nettype wire
